// [logic/srcs_pkg.sv]
package srcs_pkg;

	// Register byte addresses (printed offsets are not multiples of four: index * 4).
	localparam logic [15:0] IDX_BREAK_STATUS   = 16'hFE00;
	localparam logic [15:0] IDX_RESET_CAUSE    = 16'hFE01;
	localparam logic [15:0] IDX_BREAK_FLAG_CTL = 16'hFE03;
	localparam logic [15:0] IDX_SEQ_CONTROL    = 16'hFE04;
	localparam logic [17:0] ADDR_BREAK_STATUS   = {IDX_BREAK_STATUS, 2'h0};
	localparam logic [17:0] ADDR_RESET_CAUSE    = {IDX_RESET_CAUSE, 2'h0};
	localparam logic [17:0] ADDR_BREAK_FLAG_CTL = {IDX_BREAK_FLAG_CTL, 2'h0};
	localparam logic [17:0] ADDR_SEQ_CONTROL    = {IDX_SEQ_CONTROL, 2'h0};

	// Field positions.
	localparam int BIT_BREAK_WAIT   = 1;
	localparam int BIT_CLEAR_ENABLE = 7;
	localparam int BIT_POR          = 7;
	localparam int BIT_PIN          = 6;
	localparam int BIT_WATCHDOG     = 5;
	localparam int BIT_BAD_OPCODE   = 4;
	localparam int BIT_BAD_FETCH    = 3;
	localparam int BIT_BROWNOUT     = 1;
	localparam int BIT_PLL_SELECT   = 0;
	localparam int BIT_WAIT_MODE    = 1;

	localparam logic [7:0] RESET_CAUSE_RST = 8'h80;

	// Reset vectors.
	localparam logic [15:0] VEC_USER    = 16'hFFFE;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFE;

	// Timing in oscillator reference cycles.
	localparam int STAB_CYCLES    = 4096;
	localparam int PIN_CYCLES     = 32;
	localparam int HOLD_CYCLES    = 32;
	localparam int RELEASE_CYCLES = 64;
	localparam int PIN_MIN_CYCLES = 67;
	localparam int PIN_POR_CYCLES = 4163;
	localparam int CNT_WIDTH      = 13;
	localparam int PIN_CNT_WIDTH  = 13;

	typedef enum logic [4:0] {
		SRCS_RUN    = 5'h01,
		SRCS_STAB   = 5'h02,
		SRCS_DRIVE  = 5'h04,
		SRCS_HOLD   = 5'h08,
		SRCS_PINRST = 5'h10
	} srcs_state_e;

	// Internal reset sources, synchronised.
	typedef struct packed {
		logic power_on;
		logic brownout;
		logic watchdog;
		logic bad_opcode;
		logic bad_fetch;
	} srcs_src_s;

	// Clock enables delivered to the rest of the chip.
	typedef struct packed {
		logic cpu_en;
		logic periph_en;
		logic wait_en;
		logic clockgen_en;
	} srcs_clk_s;

endpackage

// [logic/srcs_sequencer.sv]
`timescale 1ns/1ps
// Operation
// RULE1 - User mode bus runs at one quarter of reference or PLL clock; with the PLL selected the code gives half the PLL clock.
// RULE2 - Bus clock is the clock-generator output divided by two.
// RULE3 - After power-on or brownout, clocks stay off until 4096 reference cycles pass.
// RULE4 - Wait mode stops CPU clocks but keeps two clock sets to peripherals.
// RULE5 - Every reset asserts internal reset and picks user or monitor vector.
// RULE6 - Internal reset returns all registers and modules to defaults; the code keeps the software bits through a pin reset.
// RULE7 - Prescaler clears on internal reset, untouched by pin reset.
// RULE8 - Each reset source sets its own cause bit.
// RULE9 - External reset pin held low halts all processing.
// RULE10 - Pin cause needs 67 low cycles when not power-on or brownout.
// RULE11 - After power-on or brownout, pin cause needs 4163 cycles.
// RULE12 - Internal sources drive reset pin low for 32 cycles.
// RULE13 - Internal reset stays asserted 32 more cycles after pin release.
// RULE14 - Power-on or brownout first counts 4096 cycles with pin low.
// RULE15 - Watchdog request is accepted asynchronously to the bus clock.
// RULE16 - On power-on, CPU released 64 cycles after the 4096-cycle count.
// RULE17 - Clock-generator output enabled while internal reset still asserted.
// RULE18 - Power-on sets its cause bit and clears all others.
// RULE19 - Software clears break-wait flag by writing zero; resets to zero.
// RULE20 - Prescaler is 13 bits, advancing once per reference cycle.
// RULE21 - Break flag clear enable lets other modules clear flags in break.
// RULE22 - Writes to the reset status register have no effect.
// RULE23 - Cause bits not set by the latest reset are cleared.
module srcs_sequencer #(
	parameter int STAB_COUNT = srcs_pkg::STAB_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              power_on_pulse,
	input  wire logic              brownout_req,
	input  wire logic              watchdog_req,
	input  wire logic              bad_opcode_req,
	input  wire logic              bad_fetch_req,
	input  wire logic              reset_pin_in,
	output logic                   reset_pin_out,
	output logic                   reset_pin_oe,
	input  wire logic              monitor_mode,
	input  wire logic              wait_req,
	input  wire logic              break_mode,
	input  wire logic              break_wait_set,
	input  wire logic              pll_out_clock,
	output logic                   internal_reset,
	output logic [15:0]            reset_vector,
	output logic                   bus_clk_en,
	output srcs_pkg::srcs_clk_s    clk_en,
	output logic                   flag_clear_allow,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [17:0]       wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o
);

	localparam logic [12:0] STAB_LAST = 13'(STAB_COUNT - 1);
	localparam logic [5:0] PIN_LAST  = 6'(srcs_pkg::PIN_CYCLES - 1);
	localparam logic [5:0] HOLD_LAST = 6'(srcs_pkg::HOLD_CYCLES - 1);
	localparam logic [6:0] REL_LAST  = 7'(srcs_pkg::RELEASE_CYCLES - 1);
	localparam logic [12:0] PIN_MIN  = 13'(srcs_pkg::PIN_MIN_CYCLES);
	localparam logic [12:0] PIN_POR  = 13'(srcs_pkg::PIN_POR_CYCLES);

	// Two-stage synchronisers for all asynchronous requests and the pin.
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic       pin_low;
	srcs_pkg::srcs_src_s src;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_r <= 7'h01;
			sync2_r <= 7'h01;
		end else begin
			// Watchdog and other sources arrive from foreign timing. see RULE15
			sync1_r <= {power_on_pulse, brownout_req, watchdog_req, bad_opcode_req,
				bad_fetch_req, ~reset_pin_in, pll_out_clock};
			sync2_r <= sync1_r;
		end
	end

	assign src     = srcs_pkg::srcs_src_s'(sync2_r[6:2]);
	assign pin_low = sync2_r[1];

	// Sequencer state.
	srcs_pkg::srcs_state_e state_r;
	logic [12:0]           seq_cnt_r;
	logic                  por_lvi_r;
	logic                  any_int;
	logic                  any_prev_r;
	logic                  any_new;
	logic                  por_start;

	assign any_int   = |src;
	assign any_new   = any_int && !any_prev_r;
	assign por_start = src.power_on | src.brownout;

	// A held request restarts the sequence once only, so the pin drive keeps its length.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			any_prev_r <= 1'b0;
		end else begin
			any_prev_r <= any_int;
		end
	end

	// Pin reset ignored while an internal sequence is running; internal wins.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r   <= srcs_pkg::SRCS_STAB;
			seq_cnt_r <= 13'h0000;
			por_lvi_r <= 1'b1;
		end else if (any_new) begin
			// Power-on and brownout first run the stabilisation count. see RULE14
			state_r   <= por_start ? srcs_pkg::SRCS_STAB : srcs_pkg::SRCS_DRIVE;
			seq_cnt_r <= 13'h0000;
			por_lvi_r <= por_start;
		end else begin
			unique case (state_r)
				srcs_pkg::SRCS_RUN: begin
					if (pin_low) begin
						state_r   <= srcs_pkg::SRCS_PINRST; // see RULE9
						seq_cnt_r <= 13'h0000;
					end
				end
				srcs_pkg::SRCS_PINRST: begin
					// Processing halts while the pin stays low. see RULE9
					if (!pin_low) begin
						state_r <= srcs_pkg::SRCS_RUN;
					end
				end
				srcs_pkg::SRCS_STAB: begin
					seq_cnt_r <= seq_cnt_r + 13'h0001;
					if (seq_cnt_r == STAB_LAST) begin // see RULE3
						state_r   <= srcs_pkg::SRCS_DRIVE;
						seq_cnt_r <= 13'h0000;
					end
				end
				srcs_pkg::SRCS_DRIVE: begin
					seq_cnt_r <= seq_cnt_r + 13'h0001;
					if (seq_cnt_r[5:0] == PIN_LAST) begin // see RULE12
						state_r   <= srcs_pkg::SRCS_HOLD;
						seq_cnt_r <= 13'h0000;
					end
				end
				srcs_pkg::SRCS_HOLD: begin
					seq_cnt_r <= seq_cnt_r + 13'h0001;
					if (seq_cnt_r[5:0] == HOLD_LAST) begin // see RULE13 RULE16
						state_r <= srcs_pkg::SRCS_RUN;
					end
				end
			endcase
		end
	end

	// Pin low-time counter for the pin cause bit.
	logic [12:0] pin_cnt_r;
	logic        pin_cause_hit;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_cnt_r <= 13'h0000;
		end else if (!pin_low) begin
			pin_cnt_r <= 13'h0000;
		end else if (pin_cnt_r != 13'h1FFF) begin
			pin_cnt_r <= pin_cnt_r + 13'h0001;
		end
	end

	// The longer threshold applies after power-on or brownout. see RULE10 RULE11
	assign pin_cause_hit = pin_low && (por_lvi_r ? (pin_cnt_r == PIN_POR - 13'h0001)
		: (pin_cnt_r == PIN_MIN - 13'h0001));

	// Reset cause register: only reset events change it. see RULE8 RULE22
	logic [7:0] cause_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cause_r <= srcs_pkg::RESET_CAUSE_RST; // see RULE18
		end else if (src.power_on) begin
			cause_r <= srcs_pkg::RESET_CAUSE_RST; // see RULE18
		end else if (any_int) begin
			// Latest cause replaces older ones. see RULE23
			cause_r <= 8'h00;
			cause_r[srcs_pkg::BIT_BROWNOUT]   <= src.brownout;
			cause_r[srcs_pkg::BIT_WATCHDOG]   <= src.watchdog;
			cause_r[srcs_pkg::BIT_BAD_OPCODE] <= src.bad_opcode;
			cause_r[srcs_pkg::BIT_BAD_FETCH]  <= src.bad_fetch;
		end else if (pin_cause_hit) begin
			cause_r <= 8'h00;
			cause_r[srcs_pkg::BIT_PIN] <= 1'b1; // see RULE10
		end
	end

	// Prescaler advances every reference cycle; internal resets clear it. see RULE7 RULE20
	logic [12:0] prescale_r;

	always_ff @(posedge clock) begin
		if (!rst_n || any_int) begin
			prescale_r <= 13'h0000;
		end else begin
			prescale_r <= prescale_r + 13'h0001;
		end
	end

	// Software-controlled bits, cleared by internal reset except during pin reset. see RULE6
	logic brk_wait_r;
	logic clr_en_r;
	logic pll_sel_r;
	logic wait_mode_r;
	logic in_reset;
	logic wr_take;
	logic [17:0] adr_word;

	assign in_reset = (state_r != srcs_pkg::SRCS_RUN);
	assign wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign adr_word = {wb_adr_i[17:2], 2'h0};

	always_ff @(posedge clock) begin
		if (!rst_n || (in_reset && state_r != srcs_pkg::SRCS_PINRST)) begin
			brk_wait_r  <= 1'b0;
			clr_en_r    <= 1'b0;
			pll_sel_r   <= 1'b0;
			wait_mode_r <= 1'b0;
		end else begin
			// Set wins over a simultaneous software clear. see RULE19
			if (break_wait_set) begin
				brk_wait_r <= 1'b1;
			end else if (wr_take && adr_word == srcs_pkg::ADDR_BREAK_STATUS
				&& !wb_dat_i[srcs_pkg::BIT_BREAK_WAIT]) begin
				brk_wait_r <= 1'b0;
			end
			if (wr_take && adr_word == srcs_pkg::ADDR_BREAK_FLAG_CTL) begin
				clr_en_r <= wb_dat_i[srcs_pkg::BIT_CLEAR_ENABLE];
			end
			if (wr_take && adr_word == srcs_pkg::ADDR_SEQ_CONTROL) begin
				pll_sel_r <= wb_dat_i[srcs_pkg::BIT_PLL_SELECT];
			end
			wait_mode_r <= wait_req;
		end
	end

	// Bus clock: clock-generator output is half the reference or the PLL clock
	// (edge-detected), the bus is that divided by two: a quarter of the reference, half the PLL.
	logic pll_prev_r;
	logic cg_tick;
	logic half_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pll_prev_r <= 1'b0;
			half_r     <= 1'b0;
		end else begin
			pll_prev_r <= sync2_r[0];
			if (cg_tick) begin
				half_r <= ~half_r; // see RULE2
			end
		end
	end

	// Half-rate reference, or rising PLL edges, form the clock-generator tick. see RULE1
	assign cg_tick = pll_sel_r ? (sync2_r[0] && !pll_prev_r) : prescale_r[0];

	// Outputs, all registered.
	logic run_clocks;
	assign run_clocks = !in_reset;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			internal_reset   <= 1'b1;
			reset_pin_out    <= 1'b0;
			reset_pin_oe     <= 1'b1;
			reset_vector     <= srcs_pkg::VEC_USER;
			bus_clk_en       <= 1'b0;
			clk_en           <= '0;
			flag_clear_allow <= 1'b0;
		end else begin
			internal_reset <= in_reset; // see RULE5 RULE6
			reset_vector   <= monitor_mode ? srcs_pkg::VEC_MONITOR : srcs_pkg::VEC_USER; // see RULE5
			reset_pin_out  <= 1'b0;
			// Pin driven during stabilisation and the drive phase. see RULE12 RULE14
			reset_pin_oe   <= (state_r == srcs_pkg::SRCS_STAB) || (state_r == srcs_pkg::SRCS_DRIVE);
			bus_clk_en     <= run_clocks && cg_tick && half_r; // see RULE2 RULE3
			clk_en.clockgen_en <= 1'b1; // see RULE17
			clk_en.cpu_en      <= run_clocks && !wait_mode_r; // see RULE4
			clk_en.periph_en   <= run_clocks; // see RULE4
			clk_en.wait_en     <= run_clocks && wait_mode_r; // see RULE4
			flag_clear_allow   <= break_mode && clr_en_r; // see RULE21
		end
	end

	// Wishbone classic slave: ack one cycle after request, dropped next cycle.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= 32'h0000_0000;
			unique case (adr_word)
				srcs_pkg::ADDR_BREAK_STATUS:
					wb_dat_o[srcs_pkg::BIT_BREAK_WAIT] <= brk_wait_r;
				srcs_pkg::ADDR_RESET_CAUSE:
					wb_dat_o[7:0] <= cause_r;
				srcs_pkg::ADDR_BREAK_FLAG_CTL:
					wb_dat_o[srcs_pkg::BIT_CLEAR_ENABLE] <= clr_en_r;
				srcs_pkg::ADDR_SEQ_CONTROL: begin
					wb_dat_o[srcs_pkg::BIT_PLL_SELECT] <= pll_sel_r;
					wb_dat_o[srcs_pkg::BIT_WAIT_MODE]  <= wait_mode_r;
				end
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Checks.
	a_wb_ack_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	a_pin_drive_len: assert property (@(posedge clock) disable iff (!rst_n) // see RULE12
		($rose(state_r == srcs_pkg::SRCS_DRIVE) && !any_new)
		|-> (state_r == srcs_pkg::SRCS_DRIVE)[*8]) else $error("pin drive too short");
	a_hold_follows: assert property (@(posedge clock) disable iff (!rst_n) // see RULE13
		(state_r == srcs_pkg::SRCS_DRIVE && seq_cnt_r[5:0] == PIN_LAST && !any_new)
		|=> state_r == srcs_pkg::SRCS_HOLD) else $error("hold not entered");
	a_reset_out: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
		(state_r == srcs_pkg::SRCS_HOLD) |=> internal_reset) else $error("reset dropped");
	a_por_cause: assert property (@(posedge clock) disable iff (!rst_n) // see RULE18
		src.power_on |=> cause_r == srcs_pkg::RESET_CAUSE_RST) else $error("por cause wrong");
	a_cause_wdog: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
		(src.watchdog && !src.power_on) |=> cause_r[srcs_pkg::BIT_WATCHDOG])
		else $error("watchdog cause missing");
	a_prescale_clr: assert property (@(posedge clock) disable iff (!rst_n) // see RULE7
		any_int |=> prescale_r == 13'h0000) else $error("prescaler not cleared");
	a_cpu_clk_wait: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
		wait_mode_r |=> !clk_en.cpu_en) else $error("cpu clock in wait");
	a_brk_set_win: assert property (@(posedge clock) disable iff (!rst_n) // see RULE19
		(break_wait_set && !in_reset) |=> brk_wait_r) else $error("break flag lost");
	a_clr_gate: assert property (@(posedge clock) disable iff (!rst_n) // see RULE21
		!break_mode |=> !flag_clear_allow) else $error("clear allowed outside break");

	c_por_seq: cover property (@(posedge clock) state_r == srcs_pkg::SRCS_HOLD);
	c_pin_cause: cover property (@(posedge clock) pin_cause_hit);
	c_wb_write: cover property (@(posedge clock) wr_take);
	c_wait: cover property (@(posedge clock) clk_en.wait_en);

endmodule

// [verification/srcs_far_model.sv]
`timescale 1ns/1ps
// Far side: the board reset line with its pull-up, and the PLL clock from the generator.
module srcs_far_model (
	input  wire logic clock,
	input  wire logic pull_low,
	input  wire logic reset_pin_out,
	input  wire logic reset_pin_oe,
	output logic      reset_pin_in,
	output logic      pll_out_clock
);
	logic [2:0] div_r = 3'h0;
	logic       pll_r = 1'b0;

	// The line idles high through its pull-up; either party may pull it low.
	assign reset_pin_in = ~((reset_pin_oe & ~reset_pin_out) | pull_low);
	assign pll_out_clock = pll_r;

	// The PLL clock stays well under a quarter of the reference, as the sampler needs.
	always @(posedge clock) begin
		div_r <= (div_r == 3'h5) ? 3'h0 : div_r + 3'h1;
		if (div_r == 3'h5) pll_r <= ~pll_r;
	end
endmodule

// [verification/system_reset_clock_sequencer_bench.sv]
`timescale 1ns/1ps
// Drives resets, the reset line and register traffic, and checks the sequencer's answers.
module system_reset_clock_sequencer_bench;
	localparam int STAB = 16;
	logic clock = 0, rst_n = 0, pull_low = 0, monitor_mode = 0, wait_req = 0;
	logic break_mode = 0, break_wait_set = 0, cyc = 0, stb = 0, we = 0;
	logic [4:0] src = 5'h00; // Power-on, brownout, watchdog, bad opcode, bad fetch.
	logic [17:0] adr = 18'h00000;
	logic [31:0] dat = 32'h00000000, wb_dat_o, d;
	logic reset_pin_out, reset_pin_oe, reset_pin_in, pll_out_clock, internal_reset;
	logic bus_clk_en, flag_clear_allow, wb_ack_o;
	logic [15:0] reset_vector;
	srcs_pkg::srcs_clk_s clk_en;
	int err_total = 0, comparisons = 0, ticks = 0, n;

	srcs_sequencer #(.STAB_COUNT(STAB)) u_dut (.clock, .rst_n, .power_on_pulse(src[4]),
		.brownout_req(src[3]), .watchdog_req(src[2]), .bad_opcode_req(src[1]),
		.bad_fetch_req(src[0]), .reset_pin_in, .reset_pin_out, .reset_pin_oe, .monitor_mode,
		.wait_req, .break_mode, .break_wait_set, .pll_out_clock, .internal_reset,
		.reset_vector, .bus_clk_en, .clk_en, .flag_clear_allow, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o);
	srcs_far_model u_far (.clock, .pull_low, .reset_pin_out, .reset_pin_oe, .reset_pin_in,
		.pll_out_clock);

	// A 100 ns clock, plus a cycle ceiling so that a hang still ends in a verdict.
	always #50 clock = ~clock;
	always @(posedge clock) begin
		ticks++;
		if (ticks == 30000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] v);
		int k;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		d = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Measures how long the line is driven and how long internal reset outlasts it.
	task automatic seq(input int lo, input int hi);
		int k;
		k = 0;
		while (reset_pin_oe !== 1'b1 && k < 50) begin
			@(posedge clock);
			k++;
		end
		chk(internal_reset, 1'b1);
		chk(reset_vector, monitor_mode ? srcs_pkg::VEC_MONITOR : srcs_pkg::VEC_USER);
		chk(clk_en.clockgen_en, 1'b1);
		chk(clk_en.cpu_en, 1'b0);
		chk(reset_pin_out, 1'b0);
		k = 0;
		while (reset_pin_oe === 1'b1 && k < 9000) begin
			@(posedge clock);
			k++;
		end
		chk(k >= lo && k <= hi, 1'b1);
		k = 0;
		while (internal_reset === 1'b1 && k < 200) begin
			@(posedge clock);
			k++;
		end
		chk(k, 32);
	endtask

	task automatic run_src(input int i, input int len, input logic [7:0] cause);
		@(posedge clock);
		src[i] <= 1'b1;
		repeat (4) @(posedge clock);
		src[i] <= 1'b0;
		seq(len, len);
		wb(0, srcs_pkg::ADDR_RESET_CAUSE, 0);
		chk(d, {24'h000000, cause});
	endtask

	// Pulls the line low for a number of cycles, then waits for the block to recover.
	task automatic pin(input int len);
		int k;
		@(posedge clock);
		pull_low <= 1'b1;
		repeat (len) @(posedge clock);
		chk(internal_reset, 1'b1);
		pull_low <= 1'b0;
		k = 0;
		while (internal_reset === 1'b1 && k < 100) begin
			@(posedge clock);
			k++;
		end
		wb(0, srcs_pkg::ADDR_RESET_CAUSE, 0);
	endtask

	// The test sequence, from power-up through every reset source.
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		seq(STAB + 32, STAB + 36);
		wb(0, srcs_pkg::ADDR_RESET_CAUSE, 0);
		chk(d, srcs_pkg::RESET_CAUSE_RST);
		wb(1, srcs_pkg::ADDR_RESET_CAUSE, 32'h0000007F);
		wb(0, srcs_pkg::ADDR_RESET_CAUSE, 0);
		chk(d, 32'h00000080);
		wb(0, srcs_pkg::ADDR_BREAK_STATUS, 0);
		chk(d, 32'h00000000);
		wb(0, 18'h00100, 0);
		chk(d, 32'h00000000);
		@(posedge clock) break_wait_set <= 1'b1;
		@(posedge clock) break_wait_set <= 1'b0;
		wb(0, srcs_pkg::ADDR_BREAK_STATUS, 0);
		chk(d, 32'h00000002);
		wb(1, srcs_pkg::ADDR_BREAK_STATUS, 32'h00000000);
		wb(0, srcs_pkg::ADDR_BREAK_STATUS, 0);
		chk(d, 32'h00000000);
		wb(1, srcs_pkg::ADDR_BREAK_FLAG_CTL, 32'h00000080);
		@(posedge clock) break_mode <= 1'b1;
		repeat (4) @(posedge clock);
		chk(flag_clear_allow, 1'b1);
		break_mode <= 1'b0;
		repeat (4) @(posedge clock);
		chk(flag_clear_allow, 1'b0);
		n = 0;
		repeat (64) begin
			@(posedge clock);
			if (bus_clk_en === 1'b1) n++;
		end
		chk(n, 16);
		wait_req <= 1'b1;
		repeat (6) @(posedge clock);
		chk(clk_en.cpu_en, 1'b0);
		chk(clk_en.wait_en, 1'b1);
		wait_req <= 1'b0;
		monitor_mode <= 1'b1;
		run_src(2, 32, 8'h20);
		monitor_mode <= 1'b0;
		wb(0, srcs_pkg::ADDR_BREAK_FLAG_CTL, 0);
		chk(d, 32'h00000000);
		pin(20);
		chk(d, 32'h00000020);
		pin(70);
		chk(d, 32'h00000040);
		run_src(4, STAB + 32, 8'h80);
		run_src(3, STAB + 32, 8'h02);
		pin(70);
		chk(d, 32'h00000002);
		run_src(1, 32, 8'h10);
		run_src(0, 32, 8'h08);
		give_verdict();
	end
endmodule
